// [rtl/cdr_map.svh]
`ifndef CDR_MAP_SVH
`define CDR_MAP_SVH

// Register byte offsets on the AHB-Lite slave.
`define CDR_CTRL_OFFSET      8'h00
`define CDR_STATUS_OFFSET    8'h04
`define CDR_FCOUNT_OFFSET    8'h08

// Field positions in the control register.
`define CDR_CTRL_RATE_BIT    0
`define CDR_CTRL_REFSRC_BIT  1
`define CDR_CTRL_CODE_LSB    2
`define CDR_CTRL_SQUELCH_BIT 4
`define CDR_CTRL_BYPASS_BIT  5
`define CDR_CTRL_DIAG_BIT    6
`define CDR_CTRL_WIDTH       7
`define CDR_CTRL_RESET       7'h00

// Field positions in the status register.
`define CDR_STAT_LOST_BIT    0
`define CDR_STAT_LOL_BIT     1
`define CDR_STAT_PHASE_BIT   2

// Timing of the signal-lost indication.
`define CDR_CLK_PERIOD_NS    40
`define CDR_LOS_TIME_NS      300

// Frequency window: reference ticks at the lowest reference rate.
`define CDR_WINDOW_TICKS     140000
`define CDR_FEC_NUM          15
`define CDR_FEC_DEN          14
`define CDR_PPM_ACQUIRE      500
`define CDR_PPM_RELEASE      1000
`define CDR_PPM_SCALE        1000000

`endif

// [rtl/cdr_pkg.sv]
package cdr_pkg;

   // Which loop steers the oscillator.
   typedef enum logic {
      CDR_FREQ_LOOP,
      CDR_PHASE_LOOP
   } cdr_loop_t;

endpackage

// [rtl/cdr_lock_ctrl.sv]
// What this block does
// - Rate select picks standard or wrapper rate.
// - Frequency code sets reference division ratio.
// - Crystal source ignores external input and code.
// - Reference choice independent of line rate.
// - Signal-lost output high while level below threshold.
// - Signal-lost follows level after about 300 ns.
// - Lock-lost flags full-scale noise input.
// - Clear lock-lost within 500 ppm of centre.
// - Cleared flag hands oscillator to phase loop.
// - Beyond 1000 ppm set flag, frequency loop.
// - Squelch forces clock and data to zero.
// - Bypass routes quantizer straight to data out.
// - Diagnostic enable feeds recovery from test input.
`timescale 1ns/1ns
`default_nettype none
`include "cdr_map.svh"

module cdr_lock_ctrl #(
   parameter int WINDOW_TICKS = `CDR_WINDOW_TICKS
) (
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RST,
   // AHB-Lite slave.
   input  wire logic        I_HSEL,
   input  wire logic [31:0] I_HADDR,
   input  wire logic [1:0]  I_HTRANS,
   input  wire logic        I_HWRITE,
   input  wire logic [2:0]  I_HSIZE,
   input  wire logic [31:0] I_HWDATA,
   input  wire logic        I_HREADY,
   output logic      [31:0] O_HRDATA,
   output logic             O_HREADYOUT,
   output logic             O_HRESP,
   // Analog core and front end, all sampled on the system clock.
   input  wire logic        I_LEVEL_BELOW_THR,
   input  wire logic        I_EXT_REF_TICK,
   input  wire logic        I_XTAL_TICK,
   input  wire logic        I_VCO_DIV_TICK,
   input  wire logic        I_SERIAL_LINE_IN,
   input  wire logic        I_DIAG_SERIAL_IN,
   input  wire logic        I_RECOVERED_CLK,
   input  wire logic        I_RETIMED_DATA,
   output logic             O_SIGNAL_LOST_OUT,
   output logic             O_LOCK_LOST_FLAG,
   output logic             O_PHASE_LOOP_EN,
   output logic             O_VCO_RATE,
   output logic             O_EXT_REF_EN,
   output logic      [1:0]  O_REF_DIV_CODE,
   output logic             O_CDR_INPUT,
   output logic             O_CLK_OUT,
   output logic             O_DATA_OUT
);

   // Signal-lost delay; the longest time rounds down to whole cycles.
   localparam int LOS_CYC_RAW = `CDR_LOS_TIME_NS / `CDR_CLK_PERIOD_NS;
   localparam int LOS_CYC     = (LOS_CYC_RAW < 1) ? 1 : LOS_CYC_RAW;
   localparam logic [3:0] LOS_LIMIT = 4'(LOS_CYC);

   // A wider window gives finer ppm resolution but slower lock reports.
   // The thresholds round down, so a tiny window can demand zero error.
   // Expected divided-oscillator counts per window for each line rate.
   localparam longint EXP_STD = longint'(WINDOW_TICKS);
   localparam longint EXP_FEC = EXP_STD * `CDR_FEC_NUM / `CDR_FEC_DEN;
   localparam longint ACQ_STD = EXP_STD * `CDR_PPM_ACQUIRE / `CDR_PPM_SCALE;
   localparam longint ACQ_FEC = EXP_FEC * `CDR_PPM_ACQUIRE / `CDR_PPM_SCALE;
   localparam longint REL_STD = EXP_STD * `CDR_PPM_RELEASE / `CDR_PPM_SCALE;
   localparam longint REL_FEC = EXP_FEC * `CDR_PPM_RELEASE / `CDR_PPM_SCALE;

   // All state of the block in one record.
   typedef struct packed {
      logic [`CDR_CTRL_WIDTH-1:0] ctrl;       // Software control bits.
      logic                        pend;       // Data phase awaiting service.
      logic                        wr;         // Pending transfer is a write.
      logic [7:0]                  addr;       // Pending byte offset.
      logic                        hready;     // Slave ready.
      logic [31:0]                 hrdata;     // Read data.
      logic [3:0]                  los_cnt;    // Cycles level disagreed.
      logic                        signal_lost;        // Signal-lost indication.
      logic [23:0]                 ref_cnt;    // Reference ticks in window.
      logic [23:0]                 vco_cnt;    // Oscillator ticks in window.
      logic [23:0]                 last_cnt;   // Last complete window count.
      cdr_pkg::cdr_loop_t          loop;       // Loop owning the oscillator.
      logic                        vco_rate;
      logic                        ext_en;
      logic [1:0]                  div_code;
      logic                        cdr_in;
      logic                        clk_out;
      logic                        data_out;
   } cdr_state_t;

   // Current and next copies of the whole state; only the flop writes st.
   cdr_state_t st;
   cdr_state_t next_st;

   // Decoded control bits.
   logic       rate_sel;
   logic       ref_source_select;
   logic [1:0] ref_freq_code;
   logic       squelch;
   logic       bypass;
   logic       diag_path_enable;

   assign rate_sel          = st.ctrl[`CDR_CTRL_RATE_BIT];
   assign ref_source_select = st.ctrl[`CDR_CTRL_REFSRC_BIT];
   assign ref_freq_code     = st.ctrl[`CDR_CTRL_CODE_LSB +: 2];
   assign squelch           = st.ctrl[`CDR_CTRL_SQUELCH_BIT];
   assign bypass            = st.ctrl[`CDR_CTRL_BYPASS_BIT];
   assign diag_path_enable  = st.ctrl[`CDR_CTRL_DIAG_BIT];

   // Window length and thresholds for the current settings.
   logic [23:0] win_len;
   logic [23:0] exp_cnt;
   logic [23:0] tol_acq;
   logic [23:0] tol_rel;
   logic        ref_tick;

   // The crystal runs at the lowest reference rate, so the code is moot.
   always_comb begin
      if (ref_source_select) begin
         ref_tick = I_EXT_REF_TICK;
         win_len  = 24'(EXP_STD) << ref_freq_code;
      end else begin
         ref_tick = I_XTAL_TICK;
         win_len  = 24'(EXP_STD);
      end
   end

   // The expected count and both thresholds follow the rate; the window does not.
   always_comb begin
      if (rate_sel) begin
         exp_cnt = 24'(EXP_FEC);
         tol_acq = 24'(ACQ_FEC);
         tol_rel = 24'(REL_FEC);
      end else begin
         exp_cnt = 24'(EXP_STD);
         tol_acq = 24'(ACQ_STD);
         tol_rel = 24'(REL_STD);
      end
   end

   // Absolute frequency error of a finishing window.
   logic [23:0] err;
   logic [23:0] vco_final;
   logic        win_end;

   assign win_end   = ref_tick && (st.ref_cnt + 24'h000001 >= win_len);
   assign vco_final = st.vco_cnt + {23'h000000, I_VCO_DIV_TICK};
   assign err       = (vco_final >= exp_cnt) ? vco_final - exp_cnt
                                             : exp_cnt - vco_final;

   // AHB address phase taken on a selected, non-idle transfer.
   logic take;
   assign take = I_HSEL && I_HTRANS[1] && I_HREADY;

   // Next-state logic for the whole block.
   always_comb begin
      next_st = st;

      // Bus slave: one wait cycle so a read sees any preceding write.
      // Writes land at the edge that ends the wait state, so a read that
      // follows at once already sees the new control word.
      next_st.hready = 1'b1;
      next_st.pend   = 1'b0;
      if (st.pend) begin
         if (st.wr) begin
            if (st.addr == `CDR_CTRL_OFFSET) begin
               next_st.ctrl = I_HWDATA[`CDR_CTRL_WIDTH-1:0];
            end
            next_st.hrdata = 32'h00000000;
         end else begin
            case (st.addr)
               `CDR_CTRL_OFFSET: begin
                  next_st.hrdata = {25'h0000000, st.ctrl};
               end
               `CDR_STATUS_OFFSET: begin
                  next_st.hrdata = 32'h00000000;
                  next_st.hrdata[`CDR_STAT_LOST_BIT]  = st.signal_lost;
                  next_st.hrdata[`CDR_STAT_LOL_BIT]   =
                     (st.loop == cdr_pkg::CDR_FREQ_LOOP);
                  next_st.hrdata[`CDR_STAT_PHASE_BIT] =
                     (st.loop == cdr_pkg::CDR_PHASE_LOOP);
               end
               `CDR_FCOUNT_OFFSET: begin
                  next_st.hrdata = {8'h00, st.last_cnt};
               end
               default: begin
                  // Unmapped offsets read as zero with an OKAY answer.
                  next_st.hrdata = 32'h00000000;
               end
            endcase
         end
      end else if (take) begin
         next_st.pend   = 1'b1;
         next_st.wr     = I_HWRITE;
         next_st.addr   = {I_HADDR[7:2], 2'b00};
         next_st.hready = 1'b0;
      end

      // Level must disagree for the full delay before the flag moves.
      // The same delay guards both directions, so the flag cannot chatter
      // when the level hovers at the threshold.
      if (I_LEVEL_BELOW_THR != st.signal_lost) begin
         if (st.los_cnt + 4'h1 >= LOS_LIMIT) begin
            next_st.signal_lost     = I_LEVEL_BELOW_THR;
            next_st.los_cnt = 4'h0;
         end else begin
            next_st.los_cnt = st.los_cnt + 4'h1;
         end
      end else begin
         next_st.los_cnt = 4'h0;
      end

      // Frequency window: count oscillator ticks against reference ticks.
      // A full window is needed before any verdict, so the loops swap at
      // most once per window and a brief glitch cannot flip them.
      if (win_end) begin
         next_st.ref_cnt  = 24'h000000;
         next_st.vco_cnt  = 24'h000000;
         next_st.last_cnt = vco_final;
         case (st.loop)
            cdr_pkg::CDR_FREQ_LOOP: begin
               // Noise never settles inside the band, so the flag stays.
               if (err <= tol_acq) begin
                  next_st.loop = cdr_pkg::CDR_PHASE_LOOP;
               end
            end
            cdr_pkg::CDR_PHASE_LOOP: begin
               if (err > tol_rel) begin
                  next_st.loop = cdr_pkg::CDR_FREQ_LOOP;
               end
            end
            default: begin
               next_st.loop = cdr_pkg::CDR_FREQ_LOOP;
            end
         endcase
      end else begin
         next_st.ref_cnt = st.ref_cnt + {23'h000000, ref_tick};
         next_st.vco_cnt = vco_final;
      end

      // Settings driven into the analog core.
      next_st.vco_rate = rate_sel;
      next_st.ext_en   = ref_source_select;
      next_st.div_code = ref_source_select ? ref_freq_code : 2'b00;

      // Recovery input; both test modes at once is undefined, diag still picks the test input.
      next_st.cdr_in = diag_path_enable ? I_DIAG_SERIAL_IN
                                        : I_SERIAL_LINE_IN;

      // Output drivers with squelch above every source.
      // Every path is retimed by one flop, which costs a cycle of latency
      // but keeps the outputs free of glitches.
      if (squelch) begin
         next_st.clk_out  = 1'b0;
         next_st.data_out = 1'b0;
      end else if (bypass) begin
         next_st.clk_out  = I_RECOVERED_CLK;
         next_st.data_out = I_SERIAL_LINE_IN;
      end else begin
         next_st.clk_out  = I_RECOVERED_CLK;
         next_st.data_out = I_RETIMED_DATA;
      end
   end

   // State register; the lock detector starts unlocked in the frequency loop.
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         st          <= '0;
         st.ctrl     <= `CDR_CTRL_RESET;
         st.hready   <= 1'b1;
         st.loop     <= cdr_pkg::CDR_FREQ_LOOP;
      end else begin
         st <= next_st;
      end
   end

   // Every output except the tied-off HRESP comes straight from the state register.
   // The lock-lost flag and the phase enable decode one state bit,
   // so they can never disagree.
   assign O_HRDATA          = st.hrdata;
   assign O_HREADYOUT       = st.hready;
   assign O_HRESP           = 1'b0;
   assign O_SIGNAL_LOST_OUT = st.signal_lost;
   assign O_LOCK_LOST_FLAG  = (st.loop == cdr_pkg::CDR_FREQ_LOOP);
   assign O_PHASE_LOOP_EN   = (st.loop == cdr_pkg::CDR_PHASE_LOOP);
   assign O_VCO_RATE        = st.vco_rate;
   assign O_EXT_REF_EN      = st.ext_en;
   assign O_REF_DIV_CODE    = st.div_code;
   assign O_CDR_INPUT       = st.cdr_in;
   assign O_CLK_OUT         = st.clk_out;
   assign O_DATA_OUT        = st.data_out;

   // HSIZE is accepted but only whole-word access is meaningful.
   logic unused_ok;
   assign unused_ok = ^{I_HSIZE, I_HADDR[31:8], I_HADDR[1:0]};

endmodule

`default_nettype wire

// [testbench/cdr_front_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Optical front end, both reference sources and the divided oscillator.
module cdr_front_model (
   input  wire logic i_clk,             // System clock.
   input  wire logic i_lose,            // High while the light is removed.
   input  wire logic i_slow,            // High to halve the oscillator rate.
   input  wire logic i_line,            // Bit to present on the serial line.
   output var  logic o_level_below = 1'b0,
   output var  logic o_line        = 1'b0,
   output var  logic o_ref_tick    = 1'b0,
   output var  logic o_xtal_tick   = 1'b0,
   output var  logic o_vco_tick    = 1'b0
);
   logic [1:0] ph = 2'h0;               // Free-running phase of all sources.
   // Ticks every other cycle keep both references exact.
   always @(posedge i_clk) begin
      ph <= ph + 2'h1;
      o_level_below <= i_lose;
      // With no light the amplifier passes noise, so the line never holds still.
      o_line <= i_lose ? ph[0] : i_line;
      o_ref_tick <= ph[0];
      o_xtal_tick <= ph[0];
      o_vco_tick <= i_slow ? (ph == 2'h0) : ph[0];
   end
endmodule
`default_nettype wire

// [testbench/cdr_lock_ctrl_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// Watches the controller pins for timing, hand-over and output-source slips.
module cdr_lock_ctrl_checker (
   input wire logic       I_SYS_CLK,
   input wire logic       I_RST,
   input wire logic       I_HSEL,
   input wire logic [1:0] I_HTRANS,
   input wire logic       I_HREADY,
   input wire logic       O_HREADYOUT,
   input wire logic       O_HRESP,
   input wire logic       I_LEVEL_BELOW_THR,
   input wire logic       I_RECOVERED_CLK,
   input wire logic       I_RETIMED_DATA,
   input wire logic       I_SERIAL_LINE_IN,
   input wire logic       I_DIAG_SERIAL_IN,
   input wire logic       O_SIGNAL_LOST_OUT,
   input wire logic       O_LOCK_LOST_FLAG,
   input wire logic       O_PHASE_LOOP_EN,
   input wire logic       O_EXT_REF_EN,
   input wire logic [1:0] O_REF_DIV_CODE,
   input wire logic       O_CDR_INPUT,
   input wire logic       O_CLK_OUT,
   input wire logic       O_DATA_OUT
);
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);
   // A taken request is answered after exactly one wait state.
   sequence s_req; I_HSEL && I_HTRANS[1] && I_HREADY; endsequence
   sequence s_wait; !O_HREADYOUT ##1 O_HREADYOUT; endsequence
   property p_bus; s_req |=> s_wait; endproperty
   a_bus: assert property (p_bus) else $error("bus wait state wrong");
   property p_resp; O_HRESP == 1'b0; endproperty
   a_resp: assert property (p_resp) else $error("bus response not okay");
   property p_phase; O_PHASE_LOOP_EN == !O_LOCK_LOST_FLAG; endproperty
   a_phase: assert property (p_phase) else $error("loop hand-over wrong");
   property p_lost_on;
      (I_LEVEL_BELOW_THR && !O_SIGNAL_LOST_OUT)[*7] |-> ##[1:2] O_SIGNAL_LOST_OUT;
   endproperty
   a_lost_on: assert property (p_lost_on) else $error("signal lost late");
   property p_lost_off;
      (!I_LEVEL_BELOW_THR && O_SIGNAL_LOST_OUT)[*7] |-> ##[1:2] !O_SIGNAL_LOST_OUT;
   endproperty
   a_lost_off: assert property (p_lost_off) else $error("signal lost stuck");
   property p_lost_cause; $rose(O_SIGNAL_LOST_OUT) |-> $past(I_LEVEL_BELOW_THR); endproperty
   a_lost_cause: assert property (p_lost_cause) else $error("signal lost no cause");
   property p_xtal; !O_EXT_REF_EN |-> O_REF_DIV_CODE == 2'h0; endproperty
   a_xtal: assert property (p_xtal) else $error("crystal code not zero");
   property p_clk; O_CLK_OUT |-> $past(I_RECOVERED_CLK); endproperty
   a_clk: assert property (p_clk) else $error("clock out from nowhere");
   property p_data; O_DATA_OUT |-> $past(I_RETIMED_DATA) || $past(I_SERIAL_LINE_IN); endproperty
   a_data: assert property (p_data) else $error("data out from nowhere");
   property p_cdr;
      !$past(I_RST) |-> O_CDR_INPUT == $past(I_SERIAL_LINE_IN)
         || O_CDR_INPUT == $past(I_DIAG_SERIAL_IN);
   endproperty
   a_cdr: assert property (p_cdr) else $error("recovery input wrong");
endmodule
bind cdr_lock_ctrl cdr_lock_ctrl_checker u_chk (.*);
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ns
`default_nettype none
// Table rows for the mode pins, then signal loss and lock hand-over by hand.
module tb;
   logic        clk = 1'b0;             // System clock, 25 MHz.
   logic        rst = 1'b1;             // Synchronous reset.
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic        hready, hresp, lvl, line, ref_t, xtal_t, vco_t;
   logic        rec_clk = 1'b0, ret_data = 1'b0, diag = 1'b0;
   logic        lose = 1'b0, slow = 1'b0, line_v = 1'b0;
   logic        lost, lock_lost_flag, phase_en, rate, ext_en, cdr_in, clk_o, data_o;
   logic [1:0]  div;
   logic [6:0]  outs;                   // Mode-pin outputs in row order.
   assign outs = {clk_o, data_o, cdr_in, rate, ext_en, div};
   int          n_fail = 0, checked = 0;
   // Rows hold control word, inputs {clk, data, line, diag}, and expected outputs.
   localparam logic [17:0] ROWS [9] = '{{7'h02, 4'hc, 7'h64}, {7'h07, 4'ha, 7'h5d},
      {7'h0a, 4'h6, 7'h36}, {7'h0e, 4'hd, 7'h67}, {7'h0d, 4'hc, 7'h68},
      {7'h1f, 4'hf, 7'h1f}, {7'h22, 4'h2, 7'h34}, {7'h42, 4'h9, 7'h54},
      {7'h32, 4'h3, 7'h14}};
   always #20 clk = ~clk;
   cdr_lock_ctrl #(.WINDOW_TICKS(1400)) dut (
      .I_SYS_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
      .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
      .I_LEVEL_BELOW_THR(lvl), .I_EXT_REF_TICK(ref_t), .I_XTAL_TICK(xtal_t),
      .I_VCO_DIV_TICK(vco_t), .I_SERIAL_LINE_IN(line), .I_DIAG_SERIAL_IN(diag),
      .I_RECOVERED_CLK(rec_clk), .I_RETIMED_DATA(ret_data), .O_SIGNAL_LOST_OUT(lost),
      .O_LOCK_LOST_FLAG(lock_lost_flag), .O_PHASE_LOOP_EN(phase_en), .O_VCO_RATE(rate),
      .O_EXT_REF_EN(ext_en), .O_REF_DIV_CODE(div), .O_CDR_INPUT(cdr_in),
      .O_CLK_OUT(clk_o), .O_DATA_OUT(data_o));
   cdr_front_model u_front (.i_clk(clk), .i_lose(lose), .i_slow(slow), .i_line(line_v),
      .o_level_below(lvl), .o_line(line), .o_ref_tick(ref_t), .o_xtal_tick(xtal_t),
      .o_vco_tick(vco_t));
   // Counts a comparison and reports a mismatch at once.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One single transfer; the address phase is held until ready is sampled high.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   // Waits a bounded time for the lock flag, since a window lasts 2800 cycles.
   task automatic wait_lol(input logic v);
      for (int k = 0; k < 9000 && lock_lost_flag !== v; k++) @(posedge clk);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #(40 * 60000);
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({lock_lost_flag, phase_en, hready, clk_o}, 32'ha);
      $display("test reset done");
      // Squelch only in its rows; bypass and diag never together.
      for (int i = 0; i < 9; i++) begin
         xfer(1'b1, 8'h00, {25'h0, ROWS[i][17:11]});
         {rec_clk, ret_data, line_v, diag} <= ROWS[i][10:7];
         repeat (4) @(posedge clk);
         check(outs, ROWS[i][6:0]);
         xfer(1'b0, 8'h00, 32'h0);
         check(rd, {25'h0, ROWS[i][17:11]});
      end
      xfer(1'b0, 8'h0c, 32'h0);
      check(rd, 32'h0);
      $display("test rows done");
      lose <= 1'b1;
      repeat (3) @(posedge clk);
      lose <= 1'b0;
      repeat (12) @(posedge clk);
      check(lost, 32'h0);
      lose <= 1'b1;
      repeat (6) @(posedge clk);
      check(lost, 32'h0);
      repeat (4) @(posedge clk);
      check(lost, 32'h1);
      xfer(1'b0, 8'h04, 32'h0);
      check(rd[0], 32'h1);
      // Software mirrors the lost flag onto squelch; both outputs must go quiet.
      xfer(1'b1, 8'h00, 32'h12);
      {rec_clk, ret_data} <= 2'h3;
      repeat (3) @(posedge clk);
      check({clk_o, data_o}, 32'h0);
      lose <= 1'b0;
      repeat (12) @(posedge clk);
      check(lost, 32'h0);
      $display("test signal loss done");
      xfer(1'b1, 8'h00, 32'h2);
      wait_lol(1'b0);
      check({lock_lost_flag, phase_en}, 32'h1);
      xfer(1'b0, 8'h04, 32'h0);
      check(rd, 32'h4);
      // Ticks coincide, so the window count equals the window length.
      xfer(1'b0, 8'h08, 32'h0);
      check(rd, 32'h578);
      slow <= 1'b1;
      wait_lol(1'b1);
      check({lock_lost_flag, phase_en}, 32'h2);
      xfer(1'b1, 8'h00, 32'hc);
      slow <= 1'b0;
      wait_lol(1'b0);
      check({lock_lost_flag, phase_en}, 32'h1);
      $display("test lock done");
      // A reset in mid-run must drop the lock and clear the control word.
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({lock_lost_flag, phase_en, hready, clk_o, lost}, 32'h14);
      xfer(1'b0, 8'h00, 32'h0);
      check(rd, 32'h0);
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
